// >>> src/epiu_defs.svh
`ifndef EPIU_DEFS_SVH
`define EPIU_DEFS_SVH

// line counts
`define EPIU_N_EXT        8
`define EPIU_N_LOW        4
`define EPIU_N_PC         13
`define EPIU_N_PC0        8
`define EPIU_ADDR_W       12

// register indices, byte address is four times the index
`define EPIU_IDX_EXT_FLAG 8'h1C
`define EPIU_IDX_EXT_EN   8'h1D
`define EPIU_IDX_PC_CTRL  8'h68
`define EPIU_IDX_SNS_LO   8'h69
`define EPIU_IDX_SNS_HI   8'h6A
`define EPIU_IDX_PC_MSK0  8'h6B
`define EPIU_IDX_PC_MSK1  8'h6C
`define EPIU_IDX_PC_FLAG  8'h1B

// reset values
`define EPIU_RST_BYTE     8'h00
`define EPIU_RST_WORD     32'h0000_0000

// sense field encodings
`define EPIU_SENSE_LOW    2'b00
`define EPIU_SENSE_ANY    2'b01
`define EPIU_SENSE_FALL   2'b10
`define EPIU_SENSE_RISE   2'b11

`endif

// >>> src/epiu_pkg.sv
`include "epiu_defs.svh"

package epiu_pkg;

  // state of one external line detector
  typedef struct packed {
    logic samp;
    logic prev;
    logic primed;
    logic flag;
  } epiu_line_st_t;

  // requests handed to the core
  typedef struct packed {
    logic [`EPIU_N_EXT-1:0] ext;
    logic [1:0]             pc;
  } epiu_req_t;

  // true when the selected edge lies between prev and cur
  function automatic logic epiu_edge_hit(input logic [1:0] sense,
                                         input logic       prev,
                                         input logic       cur);
    case (sense)
      `EPIU_SENSE_ANY:  epiu_edge_hit = prev ^ cur;
      `EPIU_SENSE_FALL: epiu_edge_hit = prev & ~cur;
      `EPIU_SENSE_RISE: epiu_edge_hit = ~prev & cur;
      default:          epiu_edge_hit = 1'b0;
    endcase
  endfunction

  // word-aligned decode of a register index
  function automatic logic epiu_hit(input logic [`EPIU_ADDR_W-1:0] addr,
                                    input logic [7:0]              idx);
    epiu_hit = (addr == {2'b00, idx, 2'b00});
  endfunction

endpackage

// >>> src/epiu_sense_line.sv
`timescale 1ns/10ps
`include "epiu_defs.svh"

module epiu_sense_line #(
  parameter bit SAMPLED = 1'b0
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // line control
  input  wire logic       sample_en,
  input  wire logic       pin,
  input  wire logic [1:0] sense,
  input  wire logic       clr,
  // results
  output logic            flag,
  output logic            level_low
);
  import epiu_pkg::*;

  epiu_line_st_t st_ff;
  epiu_line_st_t nxt_st;
  logic          cur;
  logic          hit;
  logic          is_level;

  // upper lines compare two samples, lower lines compare pin to last
  always_comb begin
    nxt_st   = st_ff;
    is_level = (sense == `EPIU_SENSE_LOW);
    cur      = SAMPLED ? st_ff.samp : pin;
    hit      = st_ff.primed & sample_en &
               epiu_edge_hit(sense, st_ff.prev, cur);
    if (sample_en) begin
      nxt_st.samp   = pin;
      // first enabled edge loads the pin into both stages, no false edge
      nxt_st.prev   = st_ff.primed ? cur : pin;
      nxt_st.primed = 1'b1;
    end
    // set beats clear; level mode holds the flag down
    if (is_level) begin
      nxt_st.flag = 1'b0;
    end else begin
      nxt_st.flag = hit | (st_ff.flag & ~clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign flag      = st_ff.flag;
  // low level needs no clock, taken straight from the pin
  assign level_low = (sense == `EPIU_SENSE_LOW) & ~pin;
endmodule

// >>> src/epiu_top.sv
// How it works
// - pins trigger even when driven as outputs
// - group 0 fires on masked toggle 7:0
// - group 1 fires on masked toggle 12:8
// - pin changes detected without the I/O clock
// - level request stays while pin low
// - edges on lines 7:4 need I/O clock
// - low levels and lines 3:0 need no I/O clock
// - vanished level ends wake and interrupt in the same cycle
// - lines 3:0 need global and own enable
// - pulses of one cycle on 3:0 caught
// - sense codes: low, any, fall, rise
// - low sense byte at index 0x69, resets zero
// - edge sets flag, ack or one clears
// - enable byte at index 0x1D, one bit each
// - lines 7:4 sampled before edge detection
// - group flags set, cleared; enables at 0x68
`timescale 1ns/10ps
`include "epiu_defs.svh"

module epiu_top #(
  parameter int N_EXT = `EPIU_N_EXT,
  parameter int N_PC  = `EPIU_N_PC
) (
  // clock, reset, clock enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`EPIU_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // core side
  input  wire logic                    global_irq_en,
  input  wire logic                    io_clk_en,
  input  wire logic [N_EXT-1:0]        vec_ack_ext,
  input  wire logic [1:0]              vec_ack_pc,
  output epiu_pkg::epiu_req_t          irq_req,
  output logic                         irq,
  output logic                         wake_req,
  // pins
  input  wire logic [N_EXT-1:0]        ext_irq_line,
  input  wire logic [N_PC-1:0]         pin_change_line
);
  import epiu_pkg::*;

  // all module state in one record
  typedef struct packed {
    logic [7:0]      ext_irq_sense_ctrl_low;
    logic [7:0]      ext_irq_sense_ctrl_high;
    logic [7:0]      ext_irq_enable_byte;
    logic [1:0]      pin_change_group_ctrl;
    logic [7:0]      pin_change_mask_group0;
    logic [4:0]      pin_change_mask_group1;
    logic [N_PC-1:0] pc_prev;
    logic            pc_primed;
    logic [1:0]      pin_change_pending_flag;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    epiu_req_t       req;
    logic            irq;
    logic            wake;
  } epiu_state_t;

  epiu_state_t       st_ff;
  epiu_state_t       nxt_st;

  // per-line detector results
  logic [N_EXT-1:0]  ext_irq_pending_flag;
  logic [N_EXT-1:0]  ext_level_low;
  logic [N_EXT-1:0]  ext_clr;
  logic [2*N_EXT-1:0] sense_all;

  // bus qualifiers
  logic              setup_ph;
  logic              access_ph;
  logic              wr_commit;
  logic              wr_lane0;
  logic [7:0]        wbyte;
  logic              hit_any;
  logic [7:0]        rd_byte;

  // pin change helpers
  logic [N_PC-1:0]   pc_toggle;
  logic [N_PC-1:0]   pc_mask_all;
  logic [1:0]        pc_set;
  logic [1:0]        pc_clr;
  logic [N_EXT-1:0]  ext_active;
  logic              wake_any;

  assign sense_all = {st_ff.ext_irq_sense_ctrl_high,
                      st_ff.ext_irq_sense_ctrl_low};

  // one detector per external line; upper half sampled on the io clock
  genvar gi;
  generate
    for (gi = 0; gi < N_EXT; gi = gi + 1) begin : g_line
      epiu_sense_line #(
        .SAMPLED (gi >= `EPIU_N_LOW)
      ) u_line (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .sample_en ((gi >= `EPIU_N_LOW) ? io_clk_en : 1'b1),
        .pin       (ext_irq_line[gi]),
        .sense     (sense_all[2*gi +: 2]),
        .clr       (ext_clr[gi]),
        .flag      (ext_irq_pending_flag[gi]),
        .level_low (ext_level_low[gi])
      );
    end
  endgenerate

  // apb phase decode
  always_comb begin
    setup_ph  = psel & ~penable;
    access_ph = psel & penable & st_ff.pready;
    wr_lane0  = pstrb[0];
    wbyte     = pwdata[7:0];
    hit_any   = epiu_hit(paddr, `EPIU_IDX_EXT_FLAG) |
                epiu_hit(paddr, `EPIU_IDX_EXT_EN)   |
                epiu_hit(paddr, `EPIU_IDX_PC_CTRL)  |
                epiu_hit(paddr, `EPIU_IDX_SNS_LO)   |
                epiu_hit(paddr, `EPIU_IDX_SNS_HI)   |
                epiu_hit(paddr, `EPIU_IDX_PC_MSK0)  |
                epiu_hit(paddr, `EPIU_IDX_PC_MSK1)  |
                epiu_hit(paddr, `EPIU_IDX_PC_FLAG);
    // an unmapped address writes nothing and answers with an error
    wr_commit = access_ph & pwrite & wr_lane0 & hit_any;
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_byte = `EPIU_RST_BYTE;
    if (epiu_hit(paddr, `EPIU_IDX_EXT_FLAG)) begin
      rd_byte = ext_irq_pending_flag;
    end else if (epiu_hit(paddr, `EPIU_IDX_EXT_EN)) begin
      rd_byte = st_ff.ext_irq_enable_byte;
    end else if (epiu_hit(paddr, `EPIU_IDX_PC_CTRL)) begin
      rd_byte = {6'h00, st_ff.pin_change_group_ctrl};
    end else if (epiu_hit(paddr, `EPIU_IDX_SNS_LO)) begin
      rd_byte = st_ff.ext_irq_sense_ctrl_low;
    end else if (epiu_hit(paddr, `EPIU_IDX_SNS_HI)) begin
      rd_byte = st_ff.ext_irq_sense_ctrl_high;
    end else if (epiu_hit(paddr, `EPIU_IDX_PC_MSK0)) begin
      rd_byte = st_ff.pin_change_mask_group0;
    end else if (epiu_hit(paddr, `EPIU_IDX_PC_MSK1)) begin
      rd_byte = {3'h0, st_ff.pin_change_mask_group1};
    end else if (epiu_hit(paddr, `EPIU_IDX_PC_FLAG)) begin
      rd_byte = {6'h00, st_ff.pin_change_pending_flag};
    end
  end

  // flag clears from a written one or from vector entry
  always_comb begin
    ext_clr = vec_ack_ext;
    if (wr_commit && epiu_hit(paddr, `EPIU_IDX_EXT_FLAG)) begin
      ext_clr = vec_ack_ext | wbyte;
    end
    pc_clr = vec_ack_pc;
    if (wr_commit && epiu_hit(paddr, `EPIU_IDX_PC_FLAG)) begin
      pc_clr = vec_ack_pc | wbyte[1:0];
    end
  end

  // pin change toggles, compared against the last pclk sample
  always_comb begin
    pc_mask_all = {st_ff.pin_change_mask_group1,
                   st_ff.pin_change_mask_group0};
    // no io clock gating here, so changes still wake from deep sleep
    pc_toggle = (pin_change_line ^ st_ff.pc_prev) &
                pc_mask_all & {N_PC{st_ff.pc_primed}};
    pc_set[0] = |pc_toggle[`EPIU_N_PC0-1:0];
    pc_set[1] = |pc_toggle[N_PC-1:`EPIU_N_PC0];
  end

  // request sources: edge flag or a low level that is still there
  always_comb begin
    ext_active = ext_irq_pending_flag | ext_level_low;
    // level wake does not wait for the level to last
    wake_any   = |(st_ff.ext_irq_enable_byte & ext_active) |
                 |(st_ff.pin_change_group_ctrl &
                   st_ff.pin_change_pending_flag);
  end

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;

    // bus answer: no wait state, data captured in the setup cycle
    nxt_st.pready = setup_ph;
    if (setup_ph) begin
      nxt_st.prdata  = {24'h000000, rd_byte};
      nxt_st.pslverr = ~hit_any;
    end else if (access_ph) begin
      nxt_st.pslverr = 1'b0;
    end

    // plain read-write configuration registers
    if (wr_commit) begin
      if (epiu_hit(paddr, `EPIU_IDX_SNS_LO)) begin
        nxt_st.ext_irq_sense_ctrl_low = wbyte;
      end
      if (epiu_hit(paddr, `EPIU_IDX_SNS_HI)) begin
        nxt_st.ext_irq_sense_ctrl_high = wbyte;
      end
      if (epiu_hit(paddr, `EPIU_IDX_EXT_EN)) begin
        nxt_st.ext_irq_enable_byte = wbyte;
      end
      if (epiu_hit(paddr, `EPIU_IDX_PC_CTRL)) begin
        nxt_st.pin_change_group_ctrl = wbyte[1:0];
      end
      if (epiu_hit(paddr, `EPIU_IDX_PC_MSK0)) begin
        nxt_st.pin_change_mask_group0 = wbyte;
      end
      if (epiu_hit(paddr, `EPIU_IDX_PC_MSK1)) begin
        nxt_st.pin_change_mask_group1 = wbyte[4:0];
      end
    end

    // pin change history; first sample after reset only primes
    nxt_st.pc_prev   = pin_change_line;
    nxt_st.pc_primed = 1'b1;

    // set wins over clear in the same cycle
    nxt_st.pin_change_pending_flag =
      pc_set | (st_ff.pin_change_pending_flag & ~pc_clr);

    // requests gated by own enable and global enable
    nxt_st.req.ext = ext_active & st_ff.ext_irq_enable_byte &
                     {N_EXT{global_irq_en}};
    nxt_st.req.pc  = st_ff.pin_change_pending_flag &
                     st_ff.pin_change_group_ctrl &
                     {2{global_irq_en}};
    nxt_st.irq     = (|nxt_st.req.ext) | (|nxt_st.req.pc);

    // wake does not need the global flag, it only restarts the clock
    nxt_st.wake    = wake_any;
  end

  // single register stage for all state; ce freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // outputs come straight from the state register
  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign irq_req = st_ff.req;
  assign irq     = st_ff.irq;
  assign wake_req = st_ff.wake;
endmodule

// >>> verification/epiu_monitor.sv
`timescale 1ns/10ps

module epiu_monitor (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb answer
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // core side
  input wire logic                global_irq_en,
  input wire epiu_pkg::epiu_req_t irq_req,
  input wire logic                irq,
  input wire logic                wake_req
);
  import epiu_pkg::*;

  // one domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer timing: exactly one access cycle
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready early");
  property p_one_wait; psel && !penable |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error alone");

  // request path: irq follows requests, gated by global flag
  property p_irq_or; irq == (|irq_req); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq mismatch");
  property p_gie_low; |irq_req.ext[3:0] |-> $past(global_irq_en); endproperty
  a_gie_low: assert property (p_gie_low) else $error("gate open");
  property p_gie_all; irq |-> $past(global_irq_en); endproperty
  a_gie_all: assert property (p_gie_all) else $error("irq ungated");
  // wake never needs the global flag, so it covers every request
  property p_wake; irq |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule

bind epiu_top epiu_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
  .irq_req(irq_req), .irq(irq), .wake_req(wake_req)
);

// >>> verification/epiu_pin_model.sv
`timescale 1ns/10ps

module epiu_pin_model (
  // clock
  input  wire logic        pclk,
  // pins
  output logic [7:0]       ext_irq_line,
  output logic [12:0]      pin_change_line
);
  // external lines idle high as if pulled up, pin change lines idle low
  initial begin
    ext_irq_line = 8'hFF;
    pin_change_line = 13'h0000;
  end

  // board changes pins after an edge and holds them
  task automatic drive(input logic [7:0] ext, input logic [12:0] pc);
    @(posedge pclk);
    ext_irq_line <= ext;
    pin_change_line <= pc;
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/10ps
`include "epiu_defs.svh"

module testbench;
  import epiu_pkg::*;
  // bus and core side
  logic                pclk, presetn, psel, penable, pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                pready, pslverr, err, irq, wake_req;
  logic                global_irq_en, io_clk_en;
  logic [7:0]          vec_ack_ext, ext_irq_line;
  logic [1:0]          vec_ack_pc;
  logic [12:0]         pin_change_line;
  epiu_req_t           irq_req;
  int                  n_mismatch, total_checks, cyc, c;

  epiu_top DUT (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(global_irq_en), .io_clk_en(io_clk_en),
    .vec_ack_ext(vec_ack_ext), .vec_ack_pc(vec_ack_pc),
    .irq_req(irq_req), .irq(irq), .wake_req(wake_req),
    .ext_irq_line(ext_irq_line), .pin_change_line(pin_change_line)
  );
  epiu_pin_model pins (
    .pclk(pclk), .ext_irq_line(ext_irq_line),
    .pin_change_line(pin_change_line)
  );

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdm(input logic [7:0] idx, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd & m, e);
  endtask

  // let the request path settle, then look away from the edge
  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; cyc = 0;
    global_irq_en = 1'b1; io_clk_en = 1'b1;
    vec_ack_ext = 8'h00; vec_ack_pc = 2'b00;
    n_mismatch = 0; total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // register reset values, access and unmapped address
    rdm(`EPIU_IDX_SNS_LO, 32'hFFFFFFFF, 32'h0);
    rdm(`EPIU_IDX_EXT_EN, 32'hFFFFFFFF, 32'h0);
    rdm(`EPIU_IDX_PC_CTRL, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, `EPIU_IDX_SNS_LO, 8'hA5);
    rdm(`EPIU_IDX_SNS_LO, 32'hFFFFFFFF, 32'hA5);
    apb(1'b1, `EPIU_IDX_PC_CTRL, 8'hFF);
    rdm(`EPIU_IDX_PC_CTRL, 32'hFFFFFFFF, 32'h3);
    apb(1'b0, 8'h70, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("registers done");
    // edge codes on line 0, set up in the safe software order
    for (c = 1; c < 4; c++) begin
      apb(1'b1, `EPIU_IDX_EXT_EN, 8'h00);
      apb(1'b1, `EPIU_IDX_SNS_LO, c[7:0]);
      apb(1'b1, `EPIU_IDX_EXT_FLAG, 8'h01);
      pins.drive(8'hFE, 13'h0000);
      settle();
      rdm(`EPIU_IDX_EXT_FLAG, 32'h1, {31'h0, c != 3});
      apb(1'b1, `EPIU_IDX_EXT_FLAG, 8'h01);
      apb(1'b1, `EPIU_IDX_EXT_EN, 8'hFF);
      pins.drive(8'hFF, 13'h0000);
      settle();
      chk({31'h0, irq_req.ext[0]}, {31'h0, c != 2});
      rdm(`EPIU_IDX_EXT_FLAG, 32'h1, {31'h0, c != 2});
    end
    // vector entry clears the pending flag
    @(posedge pclk);
    vec_ack_ext <= 8'h01;
    @(posedge pclk);
    vec_ack_ext <= 8'h00;
    rdm(`EPIU_IDX_EXT_FLAG, 32'h1, 32'h0);
    $display("edge codes done");
    // level sensing, global gate and wake
    apb(1'b1, `EPIU_IDX_EXT_EN, 8'h00);
    apb(1'b1, `EPIU_IDX_SNS_LO, 8'h00);
    apb(1'b1, `EPIU_IDX_EXT_EN, 8'h01);
    pins.drive(8'hFE, 13'h0000);
    settle();
    chk({31'h0, irq_req.ext[0]}, 32'h1);
    rdm(`EPIU_IDX_EXT_FLAG, 32'h1, 32'h0);
    global_irq_en <= 1'b0;
    settle();
    chk({30'h0, irq, wake_req}, 32'h1);
    global_irq_en <= 1'b1;
    pins.drive(8'hFF, 13'h0000);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("level done");
    // line 4 edges need the io clock
    apb(1'b1, `EPIU_IDX_SNS_HI, 8'h03);
    pins.drive(8'hEF, 13'h0000);
    settle();
    io_clk_en <= 1'b0;
    apb(1'b1, `EPIU_IDX_EXT_FLAG, 8'hFF);
    pins.drive(8'hFF, 13'h0000);
    settle();
    rdm(`EPIU_IDX_EXT_FLAG, 32'h10, 32'h0);
    io_clk_en <= 1'b1;
    pins.drive(8'hEF, 13'h0000);
    settle();
    apb(1'b1, `EPIU_IDX_EXT_FLAG, 8'hFF);
    pins.drive(8'hFF, 13'h0000);
    settle();
    rdm(`EPIU_IDX_EXT_FLAG, 32'h10, 32'h10);
    $display("sampled lines done");
    // pin change groups with masks
    apb(1'b1, `EPIU_IDX_PC_MSK0, 8'h01);
    apb(1'b1, `EPIU_IDX_PC_MSK1, 8'h10);
    apb(1'b1, `EPIU_IDX_PC_FLAG, 8'h03);
    pins.drive(8'hFF, 13'h0802);
    settle();
    rdm(`EPIU_IDX_PC_FLAG, 32'h3, 32'h0);
    pins.drive(8'hFF, 13'h0803);
    settle();
    rdm(`EPIU_IDX_PC_FLAG, 32'h3, 32'h1);
    pins.drive(8'hFF, 13'h1803);
    settle();
    rdm(`EPIU_IDX_PC_FLAG, 32'h3, 32'h3);
    chk({30'h0, irq_req.pc}, 32'h3);
    @(posedge pclk);
    vec_ack_pc <= 2'b11;
    @(posedge pclk);
    vec_ack_pc <= 2'b00;
    rdm(`EPIU_IDX_PC_FLAG, 32'h3, 32'h0);
    $display("pin change done");
    // a single-cycle low pulse on line 1 is still caught
    apb(1'b1, `EPIU_IDX_SNS_LO, 8'h08);
    apb(1'b1, `EPIU_IDX_EXT_FLAG, 8'h02);
    pins.drive(8'hFD, 13'h1803);
    pins.drive(8'hFF, 13'h1803);
    settle();
    rdm(`EPIU_IDX_EXT_FLAG, 32'h2, 32'h2);
    $display("pulse done");
    stop_test();
  end
endmodule
